// *** rtl/io_bus_if.sv ***
// Bus between the processor end and peripheral interfaces.
// Assumes one device drives the input word and ready lines of each bus.
`timescale 1ns/10ps
interface io_bus_if;
    logic [io_bus_pkg::SEL_W-1:0]  select_function_lines;
    logic                          select_valid;
    logic [io_bus_pkg::WORD_W-1:0] output_word_lines;
    logic [io_bus_pkg::WORD_W-1:0] input_word_lines;
    logic                          device_ready_line;
    logic                          reset_ready_pulse;
    logic                          control_pulse;
    logic                          master_clear_line;
    logic                          program_irq_line;

    modport proc (
        output select_function_lines,
        output select_valid,
        output output_word_lines,
        output reset_ready_pulse,
        output control_pulse,
        output master_clear_line,
        input  input_word_lines,
        input  device_ready_line,
        input  program_irq_line
    );

    modport dev (
        input  select_function_lines,
        input  select_valid,
        input  output_word_lines,
        input  reset_ready_pulse,
        input  control_pulse,
        input  master_clear_line,
        output input_word_lines,
        output device_ready_line,
        output program_irq_line
    );
endinterface : io_bus_if

// *** rtl/io_bus_pkg.sv ***
// Shared constants of the programmed I/O bus: word layout, function
// codes, timing and the processor end's software register map.
// Assumes one 125 MHz system clock shared by both ends.
package io_bus_pkg;
    localparam int WORD_W      = 16;
    localparam int FUNC_W      = 4;
    localparam int DADDR_W     = 6;
    localparam int SEL_W       = FUNC_W + DADDR_W;
    localparam int MAX_DEVICES = 20;
    // Select lines: low nibble is bus bits 7..10, upper six bits 11..16
    localparam int SEL_FUNC_LSB  = 0;
    localparam int SEL_DADDR_LSB = 4;
    // Function codes carried out by control pulses
    localparam logic [3:0] FN_MASK_SET = 4'h1;
    localparam logic [3:0] FN_MASK_CLR = 4'h2;
    localparam logic [3:0] FN_BUF_CLR  = 4'h3;
    // Operations of the processor end
    localparam logic [1:0] OP_INPUT  = 2'h0;
    localparam logic [1:0] OP_OUTPUT = 2'h1;
    localparam logic [1:0] OP_CTRL   = 2'h2;
    localparam logic [1:0] OP_SENSE  = 2'h3;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int READY_WAIT_NS = 96;
    localparam int READY_WAIT_CYC = READY_WAIT_NS / CLK_PERIOD_NS;
    localparam int CLEAR_NS      = 16;
    localparam int CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Software register map of the processor end
    localparam int REG_AW = 5;
    localparam logic [4:0] REG_CMD    = 5'h00;
    localparam logic [4:0] REG_ACC    = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_ISTAT  = 5'h0c;
    localparam logic [4:0] REG_IMASK  = 5'h10;
    localparam logic [4:0] REG_MCLR   = 5'h14;
    // Command register fields
    localparam int CMD_FUNC_LSB  = 0;
    localparam int CMD_DADDR_LSB = 4;
    localparam int CMD_OP_LSB    = 10;
    localparam int CMD_CLRACC    = 12;
    // Event bits of status and mask registers
    localparam int EV_SKIP   = 0;
    localparam int EV_NOSKIP = 1;
    localparam int EV_DEVIRQ = 2;
    localparam int EV_W      = 3;
endpackage : io_bus_pkg

// *** rtl/io_dev_end.sv ***
// Peripheral interface end of the I/O bus: address and function
// decode, data buffer, ready and interrupt-mask flip-flops.
// Assumes the processor end holds select lines steady around pulses.
`timescale 1ns/10ps
module io_dev_end #(
    parameter logic [5:0] DEV_ADDR = 6'h01,  // Own device address
    parameter int         BUF_W    = 8,      // Buffer width, 1..16
    parameter bit         IS_INPUT = 1'b1    // Input or output device
) (
    input  wire logic             clk_sys_i,   // System clock
    input  wire logic             rst_i,       // Async reset, active high
    input  wire logic [BUF_W-1:0] mech_data_i, // Word from mechanism
    input  wire logic             mech_valid_i,// Mechanism offers word
    input  wire logic             mech_ready_i,// Mechanism takes word
    output logic      [BUF_W-1:0] mech_data_o, // Word to mechanism
    output logic                  mech_valid_o,// Buffer holds output word
    output logic                  mech_ready_o,// Buffer free for input
    output logic      [3:0]       mode_o,      // Function of last transfer
    output logic                  ready_o,     // Ready flip-flop
    output logic                  mask_o,      // Interrupt mask flip-flop
    io_bus_if.dev                 bus          // I/O bus
);
    localparam int BW = (BUF_W < 1) ? 1 : (BUF_W > 16 ? 16 : BUF_W);

    // Address match on the device-select field
    function automatic logic addr_hit(input logic [9:0] sel,
                                      input logic       valid);
        addr_hit = valid
            && sel[io_bus_pkg::SEL_DADDR_LSB +: io_bus_pkg::DADDR_W]
               == DEV_ADDR;
    endfunction : addr_hit

    logic [BUF_W-1:0] buf_r;
    logic             full_r;
    logic             hit;
    logic [3:0]       func;
    logic             rr_hit;
    logic             cp_hit;
    logic             mclr;
    logic             mech_load;
    logic             mech_take;
    logic [15:0]      in_word;

    assign hit  = addr_hit(bus.select_function_lines, bus.select_valid);
    assign func = bus.select_function_lines[io_bus_pkg::SEL_FUNC_LSB +:
                                            io_bus_pkg::FUNC_W];
    assign rr_hit = hit && bus.reset_ready_pulse;
    assign cp_hit = hit && bus.control_pulse;
    assign mclr   = bus.master_clear_line;

    // Mechanism handshakes at the mechanism's own pace
    assign mech_load = IS_INPUT && !full_r && mech_valid_i;
    assign mech_take = !IS_INPUT && full_r && mech_ready_i;

    // Only the buffer's own lines carry data; the rest stay low
    always_comb begin
        in_word = 16'h0000;
        in_word[BW-1:0] = buf_r[BW-1:0];
    end

    // Data buffer: sole meeting point of bus and mechanism
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            buf_r  <= '0;
            full_r <= 1'b0;
        end else if (mclr) begin
            full_r <= 1'b0;
        end else if (cp_hit && func == io_bus_pkg::FN_BUF_CLR) begin
            full_r <= 1'b0;
        end else if (IS_INPUT) begin
            if (mech_load) begin
                buf_r  <= mech_data_i;
                full_r <= 1'b1;
            end else if (rr_hit) begin
                full_r <= 1'b0;
            end
        end else begin
            if (rr_hit && !full_r) begin
                buf_r  <= bus.output_word_lines[BUF_W-1:0];
                full_r <= 1'b1;
            end else if (mech_take) begin
                full_r <= 1'b0;
            end
        end
    end

    // Ready flip-flop
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
        end else if (mclr) begin
            ready_o <= 1'b0;
        end else if (rr_hit) begin
            ready_o <= 1'b0;
        end else begin
            // Set again only once the buffer has been serviced
            ready_o <= IS_INPUT ? full_r : !full_r;
        end
    end

    // Interrupt-mask flip-flop under program control
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_o <= 1'b0;
        end else if (mclr) begin
            mask_o <= 1'b0;
        end else if (cp_hit && func == io_bus_pkg::FN_MASK_SET) begin
            mask_o <= 1'b1;
        end else if (cp_hit && func == io_bus_pkg::FN_MASK_CLR) begin
            mask_o <= 1'b0;
        end
    end

    // Mode latched from the function field at each transfer
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode_o <= 4'h0;
        end else if (mclr) begin
            mode_o <= 4'h0;
        end else if (rr_hit) begin
            mode_o <= func;
        end
    end

    // Bus answers, registered
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus.device_ready_line <= 1'b0;
            bus.input_word_lines  <= 16'h0000;
            bus.program_irq_line  <= 1'b0;
        end else begin
            bus.device_ready_line <= hit && ready_o && !rr_hit
                                     && !mclr;
            bus.input_word_lines  <= (IS_INPUT && hit && ready_o && !mclr)
                                     ? in_word : 16'h0000;
            bus.program_irq_line  <= ready_o && mask_o && !mclr
                                     && !rr_hit;
        end
    end

    // Mechanism side outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mech_data_o  <= '0;
            mech_valid_o <= 1'b0;
            mech_ready_o <= 1'b0;
        end else begin
            mech_data_o  <= buf_r;
            mech_valid_o <= !IS_INPUT && full_r && !mech_take && !mclr;
            mech_ready_o <= IS_INPUT && !full_r && !mech_load && !mclr;
        end
    end
endmodule : io_dev_end

// *** rtl/io_proc_end.sv ***
// Processor end of the I/O bus with a small software register port.
// Assumes devices answer ready within the fixed wait window.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module io_proc_end (
    input  wire logic        clk_sys_i,   // System clock
    input  wire logic        rst_i,       // Async reset, active high
    input  wire logic [4:0]  addr_i,      // Register byte address
    input  wire logic [15:0] wdata_i,     // Write data
    input  wire logic        wr_i,        // Write strobe
    input  wire logic        rd_i,        // Read strobe
    output logic      [15:0] rdata_o,     // Read data, cycle after rd_i
    output logic             irq_o,       // Level interrupt
    io_bus_if.proc           bus          // I/O bus
);
    typedef enum logic [4:0] {
        P_IDLE = 5'b00001,
        P_SEL  = 5'b00010,
        P_WAIT = 5'b00100,
        P_XFER = 5'b01000,
        P_DONE = 5'b10000
    } pstate_t;

    pstate_t     state_r;
    logic [15:0] acc_r;
    logic [9:0]  sel_r;
    logic [1:0]  op_r;
    logic        clracc_r;
    logic        skip_r;
    logic [7:0]  wait_r;
    logic [2:0]  clr_cnt_r;
    logic [2:0]  istat_r;
    logic [2:0]  imask_r;
    logic [2:0]  ev_set;
    logic        cmd_wr;

    assign cmd_wr = wr_i && addr_i == io_bus_pkg::REG_CMD && state_r == P_IDLE;

    // Polled or interrupt-driven transfer sequencer
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= P_IDLE;
            wait_r  <= 8'h00;
            skip_r  <= 1'b0;
        end else begin
            case (state_r)
                P_IDLE: if (cmd_wr) state_r <= P_SEL;
                P_SEL: begin
                    wait_r  <= 8'h00;
                    skip_r  <= 1'b0;
                    state_r <= (op_r == io_bus_pkg::OP_CTRL) ? P_XFER : P_WAIT;
                end
                P_WAIT: begin
                    wait_r <= wait_r + 8'h01;
                    if (bus.device_ready_line) begin
                        skip_r  <= 1'b1;
                        state_r <= (op_r == io_bus_pkg::OP_SENSE) ? P_DONE
                                                                  : P_XFER;
                    end else if (wait_r ==
                        8'(io_bus_pkg::READY_WAIT_CYC - 1)) begin
                        state_r <= P_DONE;
                    end
                end
                P_XFER: state_r <= P_DONE;
                P_DONE: state_r <= P_IDLE;
                default: state_r <= P_IDLE;
            endcase
        end
    end

    // Command latch and accumulator
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            acc_r    <= 16'h0000;
            sel_r    <= 10'h000;
            op_r     <= 2'h0;
            clracc_r <= 1'b0;
        end else begin
            if (cmd_wr) begin
                sel_r    <= wdata_i[9:0];
                op_r     <= wdata_i[io_bus_pkg::CMD_OP_LSB +: 2];
                clracc_r <= wdata_i[io_bus_pkg::CMD_CLRACC];
            end
            if (wr_i && addr_i == io_bus_pkg::REG_ACC && state_r == P_IDLE)
                acc_r <= wdata_i;
            else if (state_r == P_XFER && op_r == io_bus_pkg::OP_INPUT)
                acc_r <= (clracc_r ? 16'h0000 : acc_r)
                         | bus.input_word_lines;
        end
    end

    // Bus drive, all from flops
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bus.select_function_lines <= 10'h000;
            bus.select_valid          <= 1'b0;
            bus.output_word_lines     <= 16'h0000;
            bus.reset_ready_pulse     <= 1'b0;
            bus.control_pulse         <= 1'b0;
        end else begin
            bus.select_valid          <= state_r == P_SEL
                                      || state_r == P_WAIT
                                      || state_r == P_XFER;
            bus.select_function_lines <= sel_r;
            // Word frozen while a device is selected
            if (state_r == P_IDLE)
                bus.output_word_lines <= acc_r;
            bus.reset_ready_pulse <= state_r == P_WAIT
                && bus.device_ready_line
                && (op_r == io_bus_pkg::OP_INPUT
                    || op_r == io_bus_pkg::OP_OUTPUT);
            // One cycle after select rises, inside the select window
            bus.control_pulse <= state_r == P_XFER
                && op_r == io_bus_pkg::OP_CTRL;
        end
    end

    // Master clear pulse
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clr_cnt_r             <= 3'h0;
            bus.master_clear_line <= 1'b1;
        end else begin
            if (wr_i && addr_i == io_bus_pkg::REG_MCLR)
                clr_cnt_r <= 3'(io_bus_pkg::CLEAR_CYC);
            else if (clr_cnt_r != 3'h0)
                clr_cnt_r <= clr_cnt_r - 3'h1;
            bus.master_clear_line <= clr_cnt_r != 3'h0;
        end
    end

    // Events: skip, no skip, device interrupt; set wins over clear
    always_comb begin
        ev_set = 3'h0;
        ev_set[io_bus_pkg::EV_SKIP]   = state_r == P_DONE && skip_r;
        ev_set[io_bus_pkg::EV_NOSKIP] = state_r == P_DONE && !skip_r;
        ev_set[io_bus_pkg::EV_DEVIRQ] = bus.program_irq_line;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            istat_r <= 3'h0;
            imask_r <= 3'h0;
            irq_o   <= 1'b0;
        end else begin
            if (wr_i && addr_i == io_bus_pkg::REG_ISTAT)
                istat_r <= (istat_r & ~wdata_i[2:0]) | ev_set;
            else
                istat_r <= istat_r | ev_set;
            if (wr_i && addr_i == io_bus_pkg::REG_IMASK)
                imask_r <= wdata_i[2:0];
            irq_o <= |(istat_r & imask_r);
        end
    end

    // Register read port
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                io_bus_pkg::REG_CMD:    rdata_o <= {3'h0, clracc_r, op_r,
                                                    sel_r};
                io_bus_pkg::REG_ACC:    rdata_o <= acc_r;
                io_bus_pkg::REG_STATUS: rdata_o <= {13'h0000,
                                                    bus.program_irq_line,
                                                    skip_r,
                                                    state_r != P_IDLE};
                io_bus_pkg::REG_ISTAT:  rdata_o <= {13'h0000, istat_r};
                io_bus_pkg::REG_IMASK:  rdata_o <= {13'h0000, imask_r};
                default:                rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule : io_proc_end

// *** testbench/io_bus_device_interface_test.sv ***
// Bench of two pairs: A joins an input device, B an output device.
// Assumes register reads answer in the cycle after the strobe.
`timescale 1ns/10ps
module io_bus_device_interface_test;
    typedef struct {
        logic [7:0]  w;
        logic [3:0]  fn;
        logic        clr;
        logic [15:0] acc;
    } row_t;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [4:0]  addr      = 5'h00;
    logic [15:0] wdata     = 16'h0000;
    logic [1:0]  wr_s      = 2'h0;
    logic [1:0]  rd_s      = 2'h0;
    logic [15:0] rdata_s [2];
    logic [1:0]  irq_s;
    logic [7:0]  mech_in   = 8'h00;
    logic        mech_vld  = 1'b0;
    logic        mech_take = 1'b0;
    logic [7:0]  mech_out;
    logic        out_full;
    logic [3:0]  mode_a;
    logic [1:0]  ready_s;
    logic [1:0]  mask_s;
    logic [15:0] v;
    int          fail_count  = 0;
    int          check_count = 0;
    int          cyc         = 0;
    row_t        rows [4] = '{'{8'h5a, 4'h0, 1'b1, 16'h005a},
        '{8'ha5, 4'h7, 1'b0, 16'h00ff}, '{8'h01, 4'hf, 1'b1, 16'h0001},
        '{8'h80, 4'h9, 1'b0, 16'h0081}};
    io_bus_if bus_a ();
    io_bus_if bus_b ();
    io_proc_end io_proc_end_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s[0]), .rd_i(rd_s[0]),
        .rdata_o(rdata_s[0]), .irq_o(irq_s[0]), .bus(bus_a));
    io_proc_end io_proc_end_b_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s[1]), .rd_i(rd_s[1]),
        .rdata_o(rdata_s[1]), .irq_o(irq_s[1]), .bus(bus_b));
    io_dev_end io_dev_end_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .mech_data_i(mech_in), .mech_valid_i(mech_vld),
        .mech_ready_i(mech_take), .mech_data_o(), .mech_valid_o(),
        .mech_ready_o(), .mode_o(mode_a), .ready_o(ready_s[0]),
        .mask_o(mask_s[0]), .bus(bus_a));
    io_dev_end #(.DEV_ADDR(6'h2a), .IS_INPUT(1'b0))
    io_dev_end_b_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .mech_data_i(mech_in), .mech_valid_i(mech_vld),
        .mech_ready_i(mech_take), .mech_data_o(mech_out),
        .mech_valid_o(out_full), .mech_ready_o(), .mode_o(),
        .ready_o(ready_s[1]), .mask_o(mask_s[1]), .bus(bus_b));
    io_bus_props io_bus_props_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .select_function_lines(bus_a.select_function_lines),
        .select_valid(bus_a.select_valid),
        .output_word_lines(bus_a.output_word_lines),
        .input_word_lines(bus_a.input_word_lines),
        .device_ready_line(bus_a.device_ready_line),
        .reset_ready_pulse(bus_a.reset_ready_pulse),
        .control_pulse(bus_a.control_pulse),
        .master_clear_line(bus_a.master_clear_line),
        .program_irq_line(bus_a.program_irq_line));
    task automatic conclude();
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input bit s, input logic [4:0] a,
                      input logic [15:0] d);
        @(posedge clk_sys_i);
        addr    <= a;
        wdata   <= d;
        wr_s[s] <= 1'b1;
        @(posedge clk_sys_i);
        wr_s[s] <= 1'b0;
    endtask : wr
    task automatic rd(input bit s, input logic [4:0] a,
                      output logic [15:0] d);
        @(posedge clk_sys_i);
        addr    <= a;
        rd_s[s] <= 1'b1;
        @(posedge clk_sys_i);
        rd_s[s] <= 1'b0;
        #1;
        d = rdata_s[s];
    endtask : rd
    task automatic rdchk(input bit s, input logic [4:0] a,
                         input logic [15:0] exp, input string nm);
        logic [15:0] d;
        rd(s, a, d);
        chk(nm, d, exp);
    endtask : rdchk
    // Starts one operation and polls until the processor end is idle
    task automatic run(input bit s, input logic [1:0] op,
                       input logic [5:0] da, input logic [3:0] fn,
                       input logic clr);
        logic [15:0] d;
        int n;
        wr(s, io_bus_pkg::REG_CMD, {3'h0, clr, op, da, fn});
        d = 16'h0001;
        n = 0;
        while (d[0] !== 1'b0 && n < 40) begin
            rd(s, io_bus_pkg::REG_STATUS, d);
            n++;
        end
        chk("run done", {15'h0, d[0]}, 16'h0000);
    endtask : run
    task automatic load(input logic [7:0] w);
        int n;
        @(posedge clk_sys_i);
        mech_in  <= w;
        mech_vld <= 1'b1;
        n = 0;
        while (ready_s[0] !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("loaded", {15'h0, ready_s[0]}, 16'h0001);
        mech_vld <= 1'b0;
    endtask : load
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // Clear line still seen at the first edge; settle one more
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("ready a", {15'h0, ready_s[0]}, 16'h0000);
        chk("ready b", {15'h0, ready_s[1]}, 16'h0001);
        chk("masks", {14'h0, mask_s}, 16'h0000);
        rdchk(0, io_bus_pkg::REG_STATUS, 16'h0000, "status");
        rdchk(0, 5'h1c, 16'h0000, "unmapped");
        wr(0, io_bus_pkg::REG_IMASK, 16'h0001);
        foreach (rows[k]) begin
            load(rows[k].w);
            run(0, io_bus_pkg::OP_INPUT, 6'h01, rows[k].fn, rows[k].clr);
            rdchk(0, io_bus_pkg::REG_ACC, rows[k].acc, "acc");
            rdchk(0, io_bus_pkg::REG_ISTAT, 16'h0001, "istat");
            chk("irq", {15'h0, irq_s[0]}, 16'h0001);
            chk("mode", {12'h0, mode_a}, {12'h0, rows[k].fn});
            chk("ready", {15'h0, ready_s[0]}, 16'h0000);
            wr(0, io_bus_pkg::REG_ISTAT, 16'h0007);
        end
        rdchk(0, io_bus_pkg::REG_ISTAT, 16'h0000, "istat clr");
        chk("irq clr", {15'h0, irq_s[0]}, 16'h0000);
        // Empty buffer: no input, no skip
        run(0, io_bus_pkg::OP_INPUT, 6'h01, 4'h0, 1'b0);
        rdchk(0, io_bus_pkg::REG_ISTAT, 16'h0002, "no ready");
        rdchk(0, io_bus_pkg::REG_ACC, 16'h0081, "acc kept");
        wr(0, io_bus_pkg::REG_ISTAT, 16'h0007);
        load(8'h3c);
        run(0, io_bus_pkg::OP_INPUT, 6'h02, 4'h0, 1'b0);
        rdchk(0, io_bus_pkg::REG_ISTAT, 16'h0002, "other addr");
        chk("kept", {15'h0, ready_s[0]}, 16'h0001);
        run(0, io_bus_pkg::OP_CTRL, 6'h01, io_bus_pkg::FN_MASK_SET, 1'b0);
        chk("mask set", {15'h0, mask_s[0]}, 16'h0001);
        rd(0, io_bus_pkg::REG_ISTAT, v);
        chk("dev irq", {15'h0, v[2]}, 16'h0001);
        run(0, io_bus_pkg::OP_CTRL, 6'h01, io_bus_pkg::FN_MASK_CLR, 1'b0);
        chk("mask clr", {15'h0, mask_s[0]}, 16'h0000);
        run(0, io_bus_pkg::OP_SENSE, 6'h01, 4'h0, 1'b0);
        rdchk(0, io_bus_pkg::REG_STATUS, 16'h0002, "sense");
        chk("sensed", {15'h0, ready_s[0]}, 16'h0001);
        run(0, io_bus_pkg::OP_CTRL, 6'h01, io_bus_pkg::FN_BUF_CLR, 1'b0);
        chk("buf clr", {15'h0, ready_s[0]}, 16'h0000);
        load(8'h11);
        run(0, io_bus_pkg::OP_CTRL, 6'h01, io_bus_pkg::FN_MASK_SET, 1'b0);
        wr(0, io_bus_pkg::REG_MCLR, 16'h0001);
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk("mclr", {14'h0, ready_s[0], mask_s[0]}, 16'h0000);
        wr(1, io_bus_pkg::REG_ACC, 16'h3cbe);
        run(1, io_bus_pkg::OP_OUTPUT, 6'h2a, 4'h5, 1'b0);
        chk("out word", {8'h0, mech_out}, 16'h00be);
        chk("full", {14'h0, out_full, ready_s[1]}, 16'h0002);
        run(1, io_bus_pkg::OP_OUTPUT, 6'h2a, 4'h5, 1'b0);
        rdchk(1, io_bus_pkg::REG_ISTAT, 16'h0003, "busy dev");
        rdchk(1, io_bus_pkg::REG_ACC, 16'h3cbe, "acc out");
        @(posedge clk_sys_i);
        mech_take <= 1'b1;
        @(posedge clk_sys_i);
        mech_take <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("drained", {14'h0, out_full, ready_s[1]}, 16'h0001);
        chk("mech word", {8'h0, mech_out}, 16'h00be);
        conclude();
    end
endmodule : io_bus_device_interface_test

// *** testbench/io_bus_props.sv ***
// Checker of the bus joining the processor end to one device.
// Assumes one clock and a device at DEV_ADDR with BUF_W bits.
`timescale 1ns/10ps
module io_bus_props #(
    parameter logic [5:0] DEV_ADDR = 6'h01,
    parameter int         BUF_W    = 8
) (
    input wire logic        clk_sys_i,             // Clock
    input wire logic        rst_i,                 // Reset
    input wire logic [9:0]  select_function_lines, // Select
    input wire logic        select_valid,          // Select valid
    input wire logic [15:0] output_word_lines,     // Out word
    input wire logic [15:0] input_word_lines,      // In word
    input wire logic        device_ready_line,     // Ready
    input wire logic        reset_ready_pulse,     // Reset ready
    input wire logic        control_pulse,         // Control
    input wire logic        master_clear_line,     // Clear
    input wire logic        program_irq_line       // Interrupt
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_start;
        $rose(select_valid);
    endsequence
    sequence s_hit;
        select_valid && select_function_lines[9:4] == DEV_ADDR;
    endsequence
    sequence s_answer;
        device_ready_line ##1 reset_ready_pulse;
    endsequence
    a_op_bounded: assert property (s_start |-> ##[1:16] !select_valid)
        else $error("select held too long");
    a_pulse_after_ready: assert property (reset_ready_pulse |->
        select_valid && $past(device_ready_line))
        else $error("reset ready without ready");
    a_pulse_single: assert property (reset_ready_pulse |=> !reset_ready_pulse)
        else $error("reset ready too long");
    a_ready_cleared: assert property (s_answer |-> ##2 !device_ready_line)
        else $error("ready kept after transfer");
    a_silent_unless_hit: assert property (!(select_valid &&
        select_function_lines[9:4] == DEV_ADDR) |=> !device_ready_line)
        else $error("ready without own address");
    a_upper_zero: assert property ((input_word_lines >> BUF_W) == 16'h0000)
        else $error("unused input lines driven");
    a_mask_off: assert property (s_hit ##0 (control_pulse &&
        select_function_lines[3:0] == io_bus_pkg::FN_MASK_CLR)
        |-> ##2 !program_irq_line)
        else $error("interrupt after mask clear");
    a_clear_quiets: assert property (master_clear_line |->
        ##2 (!device_ready_line && !program_irq_line))
        else $error("device active after clear");
    a_ctrl_in_select: assert property (control_pulse |->
        select_valid && $past(select_valid))
        else $error("control pulse outside select");
    a_select_steady: assert property (select_valid && $past(select_valid)
        |-> $stable(select_function_lines) && $stable(output_word_lines))
        else $error("select or word moved");
endmodule : io_bus_props
